// ==== sim/rsc_bank_assertions.sv ====
/*
  Concurrent checks on the ports of the signaling and counter bank.
  Assumes it is bound into rsc_bank, and that the bank is the only bus slave.
*/
module rsc_bank_assertions #(
  parameter int PORT_NUM = 1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic line_code_violation_in,
  input wire logic path_code_violation_in,
  input wire logic frames_out_of_sync_in,
  input wire logic e_bit_error_in,
  input wire logic far_end_a_error_in,
  input wire logic far_end_b_error_in,
  input wire logic e1_mode_out,
  input wire logic esf_mode_out
);
  localparam int BASE = 'h200 * (PORT_NUM - 1) + 'h2000 * ((PORT_NUM - 1) / 8);
  logic [29:0] off; // Word offset inside this port's window
  logic take, win, ev, rd_q, out_q, cfg_q, ev_q, e1_q, mode_q, cnt, eb, sig;
  logic [8:0] idx_q; // Index of the read now in its data phase
  assign off = haddr_in[31:2] - 30'(BASE);
  assign take = hsel_in && hready_in && htrans_in[1];
  assign win = off < 30'h200;
  assign ev = line_code_violation_in | path_code_violation_in | frames_out_of_sync_in
    | e_bit_error_in | far_end_a_error_in | far_end_b_error_in;
  assign cnt = idx_q >= rsc_pkg::RSC_IDX_LCV_HI && idx_q <= rsc_pkg::RSC_IDX_FEB_LO;
  assign eb = idx_q[8:1] == rsc_pkg::RSC_IDX_EB_HI[8:1];
  assign sig = idx_q[8:4] == rsc_pkg::RSC_IDX_SIG_FIRST[8:4];
  // History flags are sticky, so a check only runs while its premise still holds
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {rd_q, out_q, cfg_q, ev_q, e1_q, mode_q} <= 6'h00;
      idx_q <= 9'h000;
    end else begin
      rd_q <= take && !hwrite_in && win;
      out_q <= take && !hwrite_in && !win;
      cfg_q <= take && hwrite_in && win && off[8:0] == rsc_pkg::RSC_IDX_CFG;
      idx_q <= off[8:0];
      ev_q <= ev_q || ev;
      e1_q <= e1_q || e1_mode_out;
      mode_q <= mode_q || e1_mode_out || esf_mode_out;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_ready_high: assert property (hreadyout_out) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp_out) else $error("hresp not OKAY");
  chk_rdata_idle: assert property (!rd_q |-> hrdata_out == 32'h0)
    else $error("hrdata not zero outside a read");
  chk_rdata_byte: assert property (hrdata_out[31:8] == 24'h0) else $error("hrdata upper bits");
  chk_window_miss:
    assert property (out_q |-> hrdata_out == 32'h0) else $error("read outside window answered");
  chk_count_reset:
    assert property (rd_q && cnt && !ev_q |-> hrdata_out == 32'h0) else $error("count not zero");
  chk_d4_copy:
    assert property (rd_q && sig && !mode_q |-> hrdata_out[7:6] == hrdata_out[5:4]
      && hrdata_out[3:2] == hrdata_out[1:0]) else $error("D4 C/D not copied");
  chk_ebit_t1:
    assert property (rd_q && eb && !e1_q |-> hrdata_out == 32'h0) else $error("E-bit counts in T1");
  chk_cfg_mode: assert property (cfg_q |=> e1_mode_out == $past(hwdata_in[0])
    && esf_mode_out == $past(hwdata_in[1])) else $error("mode outputs not written");
endmodule

// ==== sim/tb_rsc_bank.sv ====
/*
  Self-checking bench for the signaling and counter bank of one port.
  Drives the AHB-Lite slave and the receive-path inputs directly.
*/
module tb_rsc_bank;
  timeunit 1ns;
  timeprecision 1ps;
  // Port 10 lies in the second group, so both strides shape its window
  localparam logic [29:0] BASE = 30'h3200;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, hwrite = 1'b0, sig_up = 1'b0, out_of_frame = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [5:0] ev = 6'h00; // One bit per counter, in register order
  logic [4:0] ch = 5'h00;
  logic [3:0] abcd = 4'h0;
  logic hready, hresp, e1m, esfm;
  int err_total = 0, cmp_count = 0;
  always #20 mclk_in = ~mclk_in;
  rsc_bank #(.PORT_NUM(10)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .line_code_violation_in(ev[0]), .path_code_violation_in(ev[1]),
    .frames_out_of_sync_in(ev[2]), .e_bit_error_in(ev[3]), .far_end_a_error_in(ev[4]),
    .far_end_b_error_in(ev[5]), .sig_update_in(sig_up), .sig_channel_in(ch),
    .sig_abcd_in(abcd), .out_of_frame_in(out_of_frame), .e1_mode_out(e1m), .esf_mode_out(esfm));
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded wait for hready at a rising edge; a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask
  // One single word transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [29:0] wa, input logic [31:0] wd);
    haddr <= {wa, 2'b00};
    htrans <= rsc_pkg::RSC_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic rdc(input string nm, input logic [29:0] wa, input logic [7:0] exp);
    bus(1'b0, wa, 32'h0);
    chk(nm, {24'h0, exp}, rd);
  endtask
  function automatic logic [29:0] wa(input int i);
    return BASE + 30'(i);
  endfunction
  task automatic cfg(input logic [31:0] v);
    bus(1'b1, wa(rsc_pkg::RSC_IDX_CFG), v);
  endtask
  // A gap cycle after each pulse keeps every pulse one cycle wide
  task automatic pulse(input logic [5:0] m, input int n);
    repeat (n) begin
      ev <= m;
      @(posedge mclk_in);
      ev <= 6'h00;
      @(posedge mclk_in);
    end
  endtask
  task automatic sig(input logic [4:0] c, input logic [3:0] v);
    sig_up <= 1'b1;
    ch <= c;
    abcd <= v;
    @(posedge mclk_in);
    sig_up <= 1'b0;
    @(posedge mclk_in);
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    chk("modes after reset", 32'h0, {30'h0, e1m, esfm});
    for (int i = 0; i < 12; i++) rdc("count after reset", wa('h50 + i), 8'h00);
    rdc("signaling word 01", wa(rsc_pkg::RSC_IDX_SIG_FIRST), 8'h00);
    cfg(32'h1);
    // All counters pass 255 so the high byte carries, then counter i gets i extra counts
    pulse(6'h3F, 257);
    for (int i = 1; i < 6; i++) pulse(6'h3F << i, 1);
    for (int i = 0; i < 6; i++) begin
      rdc("count high", wa('h50 + 2 * i), 8'h01);
      rdc("count low", wa('h51 + 2 * i), 8'(1 + i));
    end
    rdc("port 9 window", 30'h3051, 8'h00);
    rdc("port 11 window", 30'h3451, 8'h00);
    rdc("port 1 window", 30'h0051, 8'h00);
    cfg(32'h4);
    pulse(6'h09, 3);
    rdc("e-bit in T1", wa(rsc_pkg::RSC_IDX_EB_LO), 8'h00);
    rdc("line code high after clear", wa(rsc_pkg::RSC_IDX_LCV_HI), 8'h00);
    rdc("line code low after clear", wa(rsc_pkg::RSC_IDX_LCV_LO), 8'h03);
    cfg(32'h1);
    for (int c = 0; c < 31; c++) sig(5'(c), 4'(c) ^ 4'h5);
    // Every channel is written before the read-back, so each word holds both of its channels
    for (int w = 2; w <= 16; w++) begin
      rdc("E1 word", wa('h3F + w), {4'(w - 1) ^ 4'h5, 4'(w + 14) ^ 4'h5});
    end
    out_of_frame <= 1'b1;
    sig(5'h05, 4'hF);
    rdc("held in sync loss", wa('h45), 8'h01);
    out_of_frame <= 1'b0;
    sig(5'h05, 4'hF);
    rdc("updated after sync", wa('h45), 8'hF1);
    cfg(32'h2);
    sig(5'h01, 4'hB);
    sig(5'h0D, 4'h6);
    rdc("ESF word 01", wa('h40), 8'hB6);
    cfg(32'h0);
    sig(5'h02, 4'h9);
    sig(5'h0E, 4'h6);
    rdc("D4 word 02", wa('h41), 8'hA5);
    test_done();
  end
endmodule
bind rsc_bank rsc_bank_assertions #(.PORT_NUM(PORT_NUM)) u_chk (.mclk_in, .rst_n_in,
  .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out,
  .hresp_out, .hrdata_out, .line_code_violation_in, .path_code_violation_in,
  .frames_out_of_sync_in, .e_bit_error_in, .far_end_a_error_in, .far_end_b_error_in,
  .e1_mode_out, .esf_mode_out);

// ==== verilog/rsc_bank.sv ====
/*
  Receive-signaling and performance-counter register bank for one port.
  Holds the received ABCD signaling per channel, six 16-bit error counters
  and a small configuration word, all read over an AHB-Lite slave.
  Assumes the receive path delivers one-cycle event pulses and signaling
  updates synchronous to mclk_in, and that this slave is the only one on
  the bus, so its hreadyout is the bus hready.
*/
// The AHB-Lite register port was left to the implementer.
module rsc_bank #(
  // Port number 1..16, sets the address window of this bank
  parameter int PORT_NUM = 1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Receive path events, one-cycle pulses
  input wire logic line_code_violation_in,
  input wire logic path_code_violation_in,
  input wire logic frames_out_of_sync_in,
  input wire logic e_bit_error_in,
  input wire logic far_end_a_error_in,
  input wire logic far_end_b_error_in,
  // Receive signaling update
  input wire logic sig_update_in,
  input wire logic [4:0] sig_channel_in,
  input wire logic [3:0] sig_abcd_in,
  input wire logic out_of_frame_in,
  // Mode reflected out for the rest of the receive path
  output logic e1_mode_out,
  output logic esf_mode_out
);

  // Base index of this port's window
  localparam logic [15:0] PORT_BASE_IDX =
    16'(RSC_PORT_STRIDE_MUL(PORT_NUM));

  // Stride arithmetic kept in one place so the base stays exact
  function automatic int RSC_PORT_STRIDE_MUL(input int n);
    RSC_PORT_STRIDE_MUL = int'(rsc_pkg::RSC_PORT_STRIDE) * (n - 1)
      + int'(rsc_pkg::RSC_GROUP_STRIDE) * ((n - 1) / rsc_pkg::RSC_PORTS_PER_GROUP);
  endfunction

  // Saturating increment; a wrap would make a busy line look clean
  function automatic logic [15:0] cnt_next(input logic [15:0] cur,
                                           input logic ev,
                                           input logic clr);
    logic [15:0] base;
    base = clr ? rsc_pkg::RSC_CNT_RESET : cur;
    if (ev && (base != rsc_pkg::RSC_CNT_MAX)) begin
      cnt_next = base + rsc_pkg::RSC_CNT_ONE;
    end else begin
      cnt_next = base;
    end
  endfunction

  // Nibble of one channel out of the flattened signaling store
  function automatic logic [3:0] nib(input logic [123:0] flat,
                                     input logic [4:0] ch);
    nib = flat[ch * 4 +: 4];
  endfunction

  // Assemble one signaling word from the store for the current mode
  function automatic logic [7:0] sig_word(input logic [123:0] flat,
                                          input logic [3:0] w,
                                          input logic e1);
    logic [4:0] ch;
    ch = {1'b0, w};
    if (e1) begin
      if (w == 4'h0) begin
        // First E1 word: upper nibble is zero, spare bits below
        sig_word = {4'h0, nib(flat, 5'h00)};
      end else begin
        sig_word = {nib(flat, ch), nib(flat, ch + rsc_pkg::RSC_E1_PAIR_OFS)};
      end
    end else if (w < rsc_pkg::RSC_T1_WORDS) begin
      // T1 pairs channel w+1 with channel w+13
      sig_word = {nib(flat, ch + 5'h01),
                  nib(flat, ch + 5'h01 + rsc_pkg::RSC_T1_PAIR_OFS)};
    end else begin
      // Words past the T1 channel set read as zero
      sig_word = 8'h00;
    end
  endfunction

  // Bus capture of the address phase
  logic wr_pend_q; // Write data expected this cycle
  logic [8:0] wr_idx_q; // Index of the pending write
  logic hreadyout_q; // Always ready: no wait states
  logic [31:0] hrdata_q; // Read data launched for the data phase

  // Configuration
  logic e1_q; // E1 mode selected
  logic esf_q; // ESF framing selected (T1), else D4
  logic clr_q; // One-cycle clear of all counters

  // Counters and signaling store
  logic [15:0] cnt_q [rsc_pkg::RSC_NUM_CNT];
  logic [3:0] sig_q [rsc_pkg::RSC_NUM_CHAN];
  logic oof_q; // Registered frame-loss status for software

  // Address decode
  wire logic [29:0] rel_idx = haddr_in[31:2] - {14'h0000, PORT_BASE_IDX};
  wire logic in_port = rel_idx < {14'h0000, rsc_pkg::RSC_PORT_STRIDE};
  wire logic [8:0] idx = rel_idx[8:0];
  wire logic trans_ok = (htrans_in == rsc_pkg::RSC_HTRANS_NONSEQ) ||
                        (htrans_in == rsc_pkg::RSC_HTRANS_SEQ);
  wire logic acc = hsel_in && hready_in && trans_ok && in_port;
  wire logic rd_acc = acc && !hwrite_in;
  wire logic wr_acc = acc && hwrite_in;
  wire logic cfg_wr = wr_pend_q && (wr_idx_q == rsc_pkg::RSC_IDX_CFG);

  // Counter decode: even index is the high byte
  wire logic in_cnt = (idx >= rsc_pkg::RSC_IDX_LCV_HI) &&
                      (idx <= rsc_pkg::RSC_IDX_FEB_LO);
  wire logic [8:0] cnt_ofs = idx - rsc_pkg::RSC_IDX_LCV_HI;
  wire logic [2:0] cnt_sel = cnt_ofs[3:1];
  wire logic [15:0] cnt_val = in_cnt ? cnt_q[cnt_sel] : rsc_pkg::RSC_CNT_RESET;
  wire logic [7:0] cnt_byte = cnt_ofs[0] ? cnt_val[7:0] : cnt_val[15:8];

  // Signaling decode
  wire logic in_sig = (idx >= rsc_pkg::RSC_IDX_SIG_FIRST) &&
                      (idx <= rsc_pkg::RSC_IDX_SIG_LAST);
  wire logic [8:0] sig_ofs = idx - rsc_pkg::RSC_IDX_SIG_FIRST;
  logic [123:0] sig_flat;
  wire logic [7:0] sig_byte = sig_word(sig_flat, sig_ofs[3:0], e1_q);

  // Read selection; unmapped indices return zero
  wire logic [7:0] rd_byte =
    in_cnt ? cnt_byte :
    in_sig ? sig_byte :
    (idx == rsc_pkg::RSC_IDX_CFG) ? {6'h00, esf_q, e1_q} :
    (idx == rsc_pkg::RSC_IDX_STAT) ? {7'h00, oof_q} :
    8'h00;

  // Event vector in counter order
  wire logic [5:0] ev = {far_end_b_error_in, far_end_a_error_in,
                         e_bit_error_in && e1_q,
                         frames_out_of_sync_in, path_code_violation_in,
                         line_code_violation_in};

  // Signaling write qualification
  wire logic [4:0] max_chan = e1_q ? rsc_pkg::RSC_E1_MAX_CHAN : rsc_pkg::RSC_T1_MAX_CHAN;
  wire logic sig_ok = sig_update_in && !out_of_frame_in &&
                      (sig_channel_in <= max_chan) && (e1_q || (sig_channel_in != 5'h00));
  wire logic d4_mode = !e1_q && !esf_q;
  wire logic [3:0] sig_nib = d4_mode ?
    {sig_abcd_in[3:2], sig_abcd_in[3:2]} :
    sig_abcd_in;

  // Flatten the store for the word assembler
  always_comb begin
    for (int c = 0; c < rsc_pkg::RSC_NUM_CHAN; c++) begin
      sig_flat[c * 4 +: 4] = sig_q[c];
    end
  end

  // AHB-Lite address phase capture and read data launch
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 9'h000;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_acc;
      wr_idx_q <= wr_acc ? idx : wr_idx_q;
      // Zero wait states, so every data phase ends in one cycle
      hreadyout_q <= 1'b1;
      // Narrow data in the low byte, upper bits zero
      hrdata_q <= rd_acc ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // Configuration word; the clear bit is a one-shot, not stored
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      e1_q <= rsc_pkg::RSC_CFG_RESET[rsc_pkg::RSC_CFG_E1_BIT];
      esf_q <= rsc_pkg::RSC_CFG_RESET[rsc_pkg::RSC_CFG_ESF_BIT];
      clr_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        e1_q <= hwdata_in[rsc_pkg::RSC_CFG_E1_BIT];
        esf_q <= hwdata_in[rsc_pkg::RSC_CFG_ESF_BIT];
      end
      clr_q <= cfg_wr && hwdata_in[rsc_pkg::RSC_CFG_CLR_BIT];
    end
  end

  // Error counters; an event in the clear cycle counts as one
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < rsc_pkg::RSC_NUM_CNT; i++) begin
        cnt_q[i] <= rsc_pkg::RSC_CNT_RESET;
      end
    end else begin
      for (int i = 0; i < rsc_pkg::RSC_NUM_CNT; i++) begin
        cnt_q[i] <= cnt_next(cnt_q[i], ev[i], clr_q);
      end
    end
  end

  // Signaling store; held unchanged while frame sync is lost
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < rsc_pkg::RSC_NUM_CHAN; c++) begin
        sig_q[c] <= rsc_pkg::RSC_SIG_RESET;
      end
      oof_q <= 1'b0;
    end else begin
      if (sig_ok) begin
        sig_q[sig_channel_in] <= sig_nib;
      end
      oof_q <= out_of_frame_in;
    end
  end

  // Outputs straight from flops, except hresp_out, which is tied to OKAY
  assign hreadyout_out = hreadyout_q;
  assign hresp_out = rsc_pkg::RSC_HRESP_OKAY;
  assign hrdata_out = hrdata_q;
  assign e1_mode_out = e1_q;
  assign esf_mode_out = esf_q;

endmodule

// ==== verilog/rsc_pkg.sv ====
/*
  Constants for the receive-signaling and error-counter register bank of
  one framer port: register indices, port stride, configuration field
  positions, reset values and signaling layout figures.
  Assumes a 32-bit AHB-Lite register bus where each register index takes
  one aligned word, so the byte address is four times the index.
*/
// Notes on behaviour
// - E1 words 2-16: channel k high, k+15 low
// - ESF framing keeps all four ABCD bits
// - D4 framing copies A,B into C,D
// - Signaling frozen while frame sync lost
// - Line code violation count at 050h/051h
// - Path code violation count at 052h/053h
// - Frames-out-of-sync count at 054h/055h
// - E-bit count, E1 only, at 056h/057h
// - Far-end A count at 058h/059h
// - Far-end B count high byte at 05Ah
// - Far-end B count low byte at 05Bh
// - Port n offset 200h*(n-1)+2000h*((n-1)/8)
package rsc_pkg;

  // Register index width within one port window
  localparam int RSC_IDX_W = 9;

  // Counter register indices (high byte even, low byte odd)
  localparam logic [8:0] RSC_IDX_LCV_HI = 9'h050;
  localparam logic [8:0] RSC_IDX_LCV_LO = 9'h051;
  localparam logic [8:0] RSC_IDX_PCV_HI = 9'h052;
  localparam logic [8:0] RSC_IDX_PCV_LO = 9'h053;
  localparam logic [8:0] RSC_IDX_FOS_HI = 9'h054;
  localparam logic [8:0] RSC_IDX_FOS_LO = 9'h055;
  localparam logic [8:0] RSC_IDX_EB_HI = 9'h056;
  localparam logic [8:0] RSC_IDX_EB_LO = 9'h057;
  localparam logic [8:0] RSC_IDX_FEA_HI = 9'h058;
  localparam logic [8:0] RSC_IDX_FEA_LO = 9'h059;
  localparam logic [8:0] RSC_IDX_FEB_HI = 9'h05A;
  localparam logic [8:0] RSC_IDX_FEB_LO = 9'h05B;

  // Signaling words 01..16 occupy a contiguous run of indices
  localparam logic [8:0] RSC_IDX_SIG_FIRST = 9'h040;
  localparam logic [8:0] RSC_IDX_SIG_LAST = 9'h04F;

  // Configuration and status words
  localparam logic [8:0] RSC_IDX_CFG = 9'h070;
  localparam logic [8:0] RSC_IDX_STAT = 9'h071;

  // Port window stride and group stride, in register indices
  localparam logic [15:0] RSC_PORT_STRIDE = 16'h0200;
  localparam logic [15:0] RSC_GROUP_STRIDE = 16'h2000;
  localparam int RSC_PORTS_PER_GROUP = 8;

  // Configuration fields
  localparam int RSC_CFG_E1_BIT = 0;
  localparam int RSC_CFG_ESF_BIT = 1;
  localparam int RSC_CFG_CLR_BIT = 2;
  localparam logic [1:0] RSC_CFG_RESET = 2'h0;

  // Status fields
  localparam int RSC_STAT_OOF_BIT = 0;

  // Counters
  localparam int RSC_NUM_CNT = 6;
  localparam int RSC_CNT_W = 16;
  localparam logic [15:0] RSC_CNT_RESET = 16'h0000;
  localparam logic [15:0] RSC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] RSC_CNT_ONE = 16'h0001;
  localparam logic [2:0] RSC_CNT_EB = 3'h3;

  // Signaling store: channel 0 holds the spare bits of word 01
  localparam int RSC_NUM_CHAN = 31;
  localparam logic [4:0] RSC_E1_MAX_CHAN = 5'h1E;
  localparam logic [4:0] RSC_T1_MAX_CHAN = 5'h18;
  localparam logic [4:0] RSC_E1_PAIR_OFS = 5'h0F;
  localparam logic [4:0] RSC_T1_PAIR_OFS = 5'h0C;
  localparam logic [3:0] RSC_T1_WORDS = 4'hC;
  localparam logic [3:0] RSC_SIG_RESET = 4'h0;

  // AHB-Lite encodings
  localparam logic [1:0] RSC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RSC_HTRANS_SEQ = 2'h3;
  localparam logic RSC_HRESP_OKAY = 1'b0;

endpackage
